// >>> src/jtag_pkg.sv
// Shared constants, types and decode for the test access port
package jtag_pkg;

  // ---------------------------------------------------------------
  // Instruction register
  // ---------------------------------------------------------------
  localparam int IR_W = 4;
  typedef logic [IR_W-1:0] ir_t;

  localparam ir_t IR_EXTEST  = 4'h0;
  localparam ir_t IR_SAMPLE  = 4'h1;
  localparam ir_t IR_IDCODE  = 4'h2;
  localparam ir_t IR_HIGHZ   = 4'h3;
  localparam ir_t IR_BYPASS  = 4'hf;
  // Pattern loaded in Capture-IR; the two low bits must be 01
  localparam ir_t IR_CAPTURE = 4'h1;

  // ---------------------------------------------------------------
  // Identification word
  // ---------------------------------------------------------------
  localparam int ID_W       = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PRT_LSB = 12;
  localparam int ID_MFR_LSB = 1;
  // Arbitrary neutral values
  localparam logic [3:0]  ID_VERSION_DEF = 4'h5;
  localparam logic [15:0] ID_PART_DEF    = 16'h1234;
  localparam logic [10:0] ID_MFR_DEF     = 11'h2a5;
  localparam logic        ID_FIXED_ONE   = 1'b1;

  // ---------------------------------------------------------------
  // Boundary scan cells
  // ---------------------------------------------------------------
  localparam int BSR_IN  = 4;
  localparam int BSR_OUT = 4;
  localparam int BSR_LEN = BSR_IN + BSR_OUT;

  // ---------------------------------------------------------------
  // Controller states and data register selection
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
    ST_EX2_IR, ST_UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    DR_BYPASS, DR_BSR, DR_ID
  } dr_sel_e;

  function automatic dr_sel_e dr_decode(input ir_t ir);
    dr_sel_e sel;
    sel = DR_BYPASS;
    if (ir == IR_EXTEST || ir == IR_SAMPLE) begin
      sel = DR_BSR;
    end else if (ir == IR_IDCODE) begin
      sel = DR_ID;
    end
    return sel;
  endfunction

endpackage

// >>> src/bscan_if.sv
// Control and serial path between the controller and the boundary cells
`timescale 1ns/10ps
interface bscan_if;
  logic tdi;
  logic capture;
  logic shift;
  logic update;
  logic extest;
  logic highz;
  logic so;

  modport ctrl (
    output tdi,
    output capture,
    output shift,
    output update,
    output extest,
    output highz,
    input  so
  );

  modport cells (
    input  tdi,
    input  capture,
    input  shift,
    input  update,
    input  extest,
    input  highz,
    output so
  );
endinterface

// >>> src/bscan_cells.sv
// Boundary scan register with input cells and output cells
`timescale 1ns/10ps
module bscan_cells
  import jtag_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               arst_n,
  bscan_if.cells                  bus,
  input  wire logic [BSR_IN-1:0]  pin_in,
  input  wire logic [BSR_OUT-1:0] core_out,
  output      logic [BSR_IN-1:0]  core_in,
  output      logic [BSR_OUT-1:0] pin_out,
  output      logic [BSR_OUT-1:0] pin_oe
);

  typedef struct packed {
    logic [BSR_IN-1:0]  pin_s1;
    logic [BSR_IN-1:0]  pin_s2;
    logic [BSR_LEN-1:0] sh;
    logic [BSR_LEN-1:0] upd;
    logic [BSR_OUT-1:0] pout;
    logic [BSR_OUT-1:0] poe;
  } cells_s;

  cells_s s_r;
  cells_s s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.pin_s1 = pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    if (bus.capture) begin
      s_nxt.sh = {core_out, s_r.pin_s2};
    end else if (bus.shift) begin
      s_nxt.sh = {bus.tdi, s_r.sh[BSR_LEN-1:1]};
    end
    if (bus.update) begin
      s_nxt.upd = s_r.sh;
    end
    s_nxt.pout = bus.extest ? s_r.upd[BSR_LEN-1:BSR_IN] : core_out;
    s_nxt.poe  = bus.highz ? '0 : '1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.so  = s_r.sh[0];
  assign core_in = s_r.pin_s2;
  assign pin_out = s_r.pout;
  assign pin_oe  = s_r.poe;

endmodule

// >>> src/tap_ctrl.sv
// Test access port controller, instruction register and data registers
//
// Summary of operation
// - Five rising test clocks with TMS high always reach Test-Logic-Reset.
// - No self reset from test pins; state known only after a reset.
// - Port overrides the device function; normal mode needs reset state.
// - State changes on rising test clock, chosen by sampled TMS, or on a reset.
// - Test-Logic-Reset disables all test logic; device runs normally.
// - Run-Test-Idle activates test logic only if the instruction asks.
// - Select-DR branches to data path or Select-IR; Select-IR to Capture-IR or reset.
// - Capture-IR loads a fixed pattern ending in binary 01.
// - Shift-IR shifts instruction register between TDI and TDO.
// - Exit1-IR to Pause or Update; Pause holds; Exit2 to Shift or Update.
// - Update-IR latches the instruction on the falling test clock.
// - Capture-DR loads the selected data register on rising test clock.
// - Data path states mirror the instruction path on the selected register.
// - Instruction register is four bits, least significant bit nearest TDO.
// - Bypass, boundary and identification registers share TDI and TDO.
// - Bypass is one stage, cleared in Capture-DR when selected.
// - Shifting through bypass leaves device function unaffected.
// - Boundary register loads and reads cells at device ports.
// - Decode EXTEST 0, SAMPLE 1, IDCODE 2, HIGHZ 3, BYPASS F.
// - Identification is 32 bits: version, part, maker, bit 0 one.
// - HIGHZ floats every output and routes bypass between TDI and TDO.
`timescale 1ns/10ps
module tap_ctrl
  import jtag_pkg::*;
#(
  parameter logic [3:0]  ID_VERSION = ID_VERSION_DEF,
  parameter logic [15:0] ID_PART    = ID_PART_DEF,
  parameter logic [10:0] ID_MFR     = ID_MFR_DEF
) (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         tck,
  input  wire logic                         tms,
  input  wire logic                         tdi,
  input  wire logic                         trst_n,
  output      logic                         tdo,
  output      logic                         tdo_oe,
  input  wire logic [jtag_pkg::BSR_IN-1:0]  pin_in,
  output      logic [jtag_pkg::BSR_IN-1:0]  core_in,
  input  wire logic [jtag_pkg::BSR_OUT-1:0] core_out,
  output      logic [jtag_pkg::BSR_OUT-1:0] pin_out,
  output      logic [jtag_pkg::BSR_OUT-1:0] pin_oe,
  output      logic                         functional_mode
);

  import jtag_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    tap_state_e      st;
    ir_t             ir_sh;
    ir_t             ir;
    logic            byp;
    logic [ID_W-1:0] id_sh;
    logic            tdo;
    logic            tdo_oe;
    logic [2:0]      tck_p;
    logic [1:0]      tms_p;
    logic [1:0]      tdi_p;
    logic [1:0]      trst_p;
  } tap_s;

  localparam logic [ID_W-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, ID_FIXED_ONE};

  tap_s    s_r;
  tap_s    s_nxt;
  logic    tck_rise;
  logic    tck_fall;
  dr_sel_e sel;

  bscan_if bus ();

  // ---------------------------------------------------------------
  // Controller state graph
  // ---------------------------------------------------------------
  function automatic tap_state_e next_state(input tap_state_e st, input logic m);
    tap_state_e nx;
    nx = st;
    case (st)
      ST_RESET:  nx = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   nx = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: nx = m ? ST_SEL_IR : ST_CAP_DR;
      ST_SEL_IR: nx = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_DR: nx = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nx = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nx = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: nx = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: nx = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nx = m ? ST_SEL_DR : ST_IDLE;
      ST_CAP_IR: nx = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nx = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nx = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: nx = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: nx = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nx = m ? ST_SEL_DR : ST_IDLE;
      default:   nx = ST_RESET;
    endcase
    return nx;
  endfunction

  // ---------------------------------------------------------------
  // Test clock edges
  // ---------------------------------------------------------------
  // Stage 0 of each synchroniser feeds stage 1 only
  assign tck_rise = s_r.tck_p[1] & ~s_r.tck_p[2];
  assign tck_fall = ~s_r.tck_p[1] & s_r.tck_p[2];

  assign sel = dr_decode(s_r.ir);

  always_comb begin
    s_nxt        = s_r;
    s_nxt.tck_p  = {s_r.tck_p[1:0], tck};
    s_nxt.tms_p  = {s_r.tms_p[0], tms};
    s_nxt.tdi_p  = {s_r.tdi_p[0], tdi};
    s_nxt.trst_p = {s_r.trst_p[0], trst_n};
    bus.capture  = 1'b0;
    bus.shift    = 1'b0;
    bus.update   = 1'b0;
    if (!s_r.trst_p[1]) begin
      s_nxt.st     = ST_RESET;
      s_nxt.ir     = IR_IDCODE;
      s_nxt.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      s_nxt.st = next_state(s_r.st, s_r.tms_p[1]);
      case (s_r.st)
        ST_CAP_IR: begin
          s_nxt.ir_sh = IR_CAPTURE;
        end
        ST_SH_IR: begin
          s_nxt.ir_sh = {s_r.tdi_p[1], s_r.ir_sh[IR_W-1:1]};
        end
        ST_CAP_DR: begin
          case (sel)
            DR_BYPASS: s_nxt.byp = 1'b0;
            DR_ID:     s_nxt.id_sh = ID_WORD;
            default:   bus.capture = 1'b1;
          endcase
        end
        ST_SH_DR: begin
          case (sel)
            DR_BYPASS: s_nxt.byp = s_r.tdi_p[1];
            DR_ID:     s_nxt.id_sh = {s_r.tdi_p[1], s_r.id_sh[ID_W-1:1]};
            default:   bus.shift = 1'b1;
          endcase
        end
        default: begin
        end
      endcase
      if (s_nxt.st == ST_RESET) begin
        s_nxt.ir = IR_IDCODE;
      end
    end else if (tck_fall) begin
      s_nxt.tdo_oe = (s_r.st == ST_SH_IR) || (s_r.st == ST_SH_DR);
      if (s_r.st == ST_SH_IR) begin
        s_nxt.tdo = s_r.ir_sh[0];
      end else if (sel == DR_ID) begin
        s_nxt.tdo = s_r.id_sh[0];
      end else if (sel == DR_BSR) begin
        s_nxt.tdo = bus.so;
      end else begin
        s_nxt.tdo = s_r.byp;
      end
      if (s_r.st == ST_UPD_IR) begin
        s_nxt.ir = s_r.ir_sh;
      end
      if (s_r.st == ST_UPD_DR && sel == DR_BSR) begin
        bus.update = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r        <= '0;
      s_r.st     <= ST_RESET;
      s_r.ir     <= IR_IDCODE;
      s_r.tck_p  <= '0;
      // Held in reset until test reset seen high
      s_r.trst_p <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Boundary cells and outputs
  // ---------------------------------------------------------------
  assign bus.tdi    = s_r.tdi_p[1];
  // Test logic driven by instruction only
  // Ports taken over only under EXTEST or HIGHZ
  assign bus.extest = (s_r.ir == IR_EXTEST);
  assign bus.highz  = (s_r.ir == IR_HIGHZ);

  bscan_cells u_cells (
    .clk      (clk),
    .arst_n   (arst_n),
    .bus      (bus.cells),
    .pin_in   (pin_in),
    .core_out (core_out),
    .core_in  (core_in),
    .pin_out  (pin_out),
    .pin_oe   (pin_oe)
  );

  assign tdo    = s_r.tdo;
  assign tdo_oe = s_r.tdo_oe;
  assign functional_mode = (s_r.st == ST_RESET);

endmodule

// >>> tb/tap_ctrl_properties.sv
// Concurrent checks on the test access port pins
`timescale 1ns/10ps
module tap_ctrl_properties
  import jtag_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         arst_n,
  input wire logic                         tck,
  input wire logic                         tms,
  input wire logic                         tdi,
  input wire logic                         trst_n,
  input wire logic                         tdo,
  input wire logic                         tdo_oe,
  input wire logic [jtag_pkg::BSR_IN-1:0]  pin_in,
  input wire logic [jtag_pkg::BSR_IN-1:0]  core_in,
  input wire logic [jtag_pkg::BSR_OUT-1:0] core_out,
  input wire logic [jtag_pkg::BSR_OUT-1:0] pin_out,
  input wire logic [jtag_pkg::BSR_OUT-1:0] pin_oe,
  input wire logic                         functional_mode
);
  // -------------------------------------------------------------
  // Count of consecutive test clock rises seen with tms high, cleared by a rise with tms low, saturating at 5
  // -------------------------------------------------------------
  logic [2:0] ones_r;
  logic       tck_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ones_r <= 3'h0;
      tck_r <= 1'b0;
    end else begin
      tck_r <= tck;
      if (tck && !tck_r) begin
        ones_r <= !tms ? 3'h0 : (ones_r == 3'h5 ? ones_r : ones_r + 3'h1);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_trst_held;
    !trst_n [*3];
  endsequence
  sequence s_fm_settled;
    functional_mode [*2];
  endsequence

  property p_five_ones;
    ones_r == 3'h5 |-> ##[1:6] functional_mode;
  endproperty
  property p_trst;
    s_trst_held |-> ##[1:2] functional_mode;
  endproperty
  property p_fm_quiet;
    functional_mode |-> !tdo_oe;
  endproperty
  property p_fm_pins;
    s_fm_settled |-> pin_oe == '1 && pin_out == $past(core_out);
  endproperty
  property p_leave_reset;
    $fell(functional_mode) |-> $past(tck) && $past(tck, 2);
  endproperty
  property p_tdo_fall;
    $changed(tdo) |-> !$past(tck) && !$past(tck, 2);
  endproperty
  property p_oe_rise;
    $rose(tdo_oe) |-> !$past(tck) && !$past(tck, 2) && !functional_mode;
  endproperty
  property p_highz_fall;
    $fell(pin_oe[0]) |-> !$past(tck) && !$past(tck, 2) && pin_oe == '0;
  endproperty
  property p_oe_uniform;
    pin_oe == '0 || pin_oe == '1;
  endproperty

  a_five_ones: assert property (p_five_ones) else $error("no reset after five tms ones");
  a_trst: assert property (p_trst) else $error("test reset pin ignored");
  a_fm_quiet: assert property (p_fm_quiet) else $error("tdo driven in reset state");
  a_fm_pins: assert property (p_fm_pins) else $error("pins not functional in reset");
  a_leave_reset: assert property (p_leave_reset) else $error("state left off tck rise");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off tck fall");
  a_oe_rise: assert property (p_oe_rise) else $error("tdo enable rose badly");
  a_highz_fall: assert property (p_highz_fall) else $error("output float not on fall");
  a_oe_uniform: assert property (p_oe_uniform) else $error("output enables split");
endmodule

bind tap_ctrl tap_ctrl_properties u_props (
  .clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
  .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_in(core_in), .core_out(core_out),
  .pin_out(pin_out), .pin_oe(pin_oe), .functional_mode(functional_mode)
);

// >>> tb/jtag_tester.sv
// Model of the external tester driving the test pins
`timescale 1ns/10ps
module jtag_tester (
  input  wire logic clk,
  input  wire logic tdo,
  output      logic tck,
  output      logic tms,
  output      logic tdi,
  output      logic trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
  end

  // Pins set at the tck fall; tdo of the previous fall is read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (4) @(negedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (4) @(negedge clk);
    tck <= 1'b0;
  endtask

  task automatic walk(input logic [7:0] pat, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(pat[i], ~tdi, q);
    end
  endtask

  task automatic pin_reset();
    trst_n <= 1'b0;
    repeat (4) @(negedge clk);
    trst_n <= 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // From Run-Test-Idle: shift n bits LSB first, then leave by the tail path
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, input logic [7:0] tail = 8'h01,
                      input int tn = 2);
    logic q;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(tail, tn);
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the test access port
`timescale 1ns/10ps
module tb_top;
  import jtag_pkg::*;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic [BSR_IN-1:0]   pin_in = 4'h9;
  logic [BSR_OUT-1:0]  core_out = 4'h3;
  logic                tck, tms, tdi, trst_n, tdo, tdo_oe, functional_mode;
  logic [BSR_IN-1:0]   core_in;
  logic [BSR_OUT-1:0]  pin_out, pin_oe;
  int                  fail_count = 0;
  int                  n_checks = 0;
  int                  cycles = 0;
  localparam logic [31:0] id_word = {ID_VERSION_DEF, ID_PART_DEF, ID_MFR_DEF, 1'b1};

  always #50 clk = ~clk;

  tap_ctrl uut (
    .clk(clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_in(core_in), .core_out(core_out),
    .pin_out(pin_out), .pin_oe(pin_oe), .functional_mode(functional_mode)
  );
  jtag_tester tst (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));

  // -------------------------------------------------------------
  // Checking and closing
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs about 2200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic t_reset_id();
    logic [31:0] d;
    tst.pin_reset();
    chk(functional_mode, 1'b1);
    chk(pin_oe, 4'hf);
    tst.walk(8'h00, 1);
    chk(functional_mode, 1'b0);
    tst.scan(1'b0, 32, 32'h0, d);
    chk(d, id_word);
  endtask

  // Each code is followed by an 8-bit scan; one captured zero leads the data
  task automatic t_bypass();
    logic [31:0] d;
    ir_t         codes [4] = '{IR_BYPASS, IR_HIGHZ, 4'h7, 4'ha};
    foreach (codes[i]) begin
      if (codes[i] == IR_HIGHZ) begin
        tst.scan(1'b1, 4, codes[i], d, 8'h0c, 5);
      end else begin
        tst.scan(1'b1, 4, codes[i], d);
      end
      chk(d[1:0], 2'b01);
      chk(pin_oe, codes[i] == IR_HIGHZ ? 4'h0 : 4'hf);
      tst.scan(1'b0, 8, 32'hb6, d);
      chk(d[7:0], 8'h6c);
      chk(core_in, 4'h9);
    end
  endtask

  task automatic t_boundary();
    logic [31:0] d;
    tst.scan(1'b1, 4, IR_SAMPLE, d);
    tst.scan(1'b0, 8, 32'h5a, d);
    chk(d[7:0], 8'h39);
    tst.scan(1'b1, 4, IR_EXTEST, d);
    chk(pin_out, 4'h5);
    tst.walk(8'h01, 3);
    tst.walk(8'h0f, 4);
    chk(functional_mode, 1'b0);
    tst.walk(8'h01, 1);
    chk(functional_mode, 1'b1);
    chk(pin_out, 4'h3);
    tst.walk(8'h00, 1);
    tst.scan(1'b0, 32, 32'h0, d);
    chk(d, id_word);
  endtask

  task automatic t_trst();
    logic [31:0] d;
    tst.scan(1'b1, 4, IR_BYPASS, d);
    tst.walk(8'h03, 4);
    tst.walk(8'h00, 1);
    chk(tdo_oe, 1'b1);
    tst.pin_reset();
    chk(functional_mode, 1'b1);
    chk(tdo_oe, 1'b0);
    tst.walk(8'h00, 1);
    tst.scan(1'b1, 4, IR_IDCODE, d);
    tst.scan(1'b0, 32, 32'h0, d);
    chk(d, id_word);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    arst_n <= 1'b1;
    t_reset_id();
    t_bypass();
    t_boundary();
    t_trst();
    stop_test();
  end
endmodule
